// ---- logic/server_reset_and_boot_failover.sv ----
// reset sequencer, boot failover timer and management interrupt routing
// Notes on behaviour
// - failover timer starts at power-up; halt stops it
// - timeout unhalted: stop-flush, failover reset 10 ms
// - after failover reset, processor 0 excluded
// - cpu power good only after stable power
// - board controller reset, clocks follow power good
// - bridge reset only after processor init done
// - host bridge reset passed on to io
// - three reset causes: power-up, warm, soft
// - soft reset accepted from three sources
// - soft reset keeps caches, resets bus, cpus
// - mgmt interrupt low while any monitor faulted
// - gated mgmt interrupt and nmi drive serr
// - main power switched by any power request
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module server_reset_and_boot_failover #(
    parameter int FAILOVER_TIMEOUT = reset_seq_pkg::FAILOVER_TIMEOUT_CYC,
    parameter int FAILOVER_RESET   = reset_seq_pkg::FAILOVER_RESET_CYC,
    parameter int PGOOD_STABLE     = reset_seq_pkg::PGOOD_STABLE_CYC,
    parameter int BRIDGE_RESET     = reset_seq_pkg::BRIDGE_RESET_CYC,
    parameter int CPU_RESET        = reset_seq_pkg::CPU_RESET_CYC
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    // avalon-mm slave
    input  wire logic [3:0]                  i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [31:0]                 i_avs_writedata,
    output logic [31:0]                      o_avs_readdata,
    output logic                             o_avs_waitrequest,
    output logic                             o_irq,
    // power and reset sources
    input  wire logic [3:0]                  i_power_req,
    input  wire logic                        i_power_stable,
    input  wire logic                        i_cpu_init_done,
    input  wire logic                        i_failover_timer_halt_n,
    input  wire logic [2:0]                  i_soft_reset_req,
    input  wire logic [3:0]                  i_monitor_fault,
    input  wire logic                        i_nmi,
    // board side
    output reset_seq_pkg::board_out_type     o_board,
    output logic                             o_mgmt_interrupt_n,
    output logic                             o_pci_serr_n
);

    reset_seq_pkg::state_type s_q;
    reset_seq_pkg::state_type s_d;

    logic        req;
    logic        wr_hit;
    logic        warm_req;
    logic        soft_req;
    logic        power_toggle;
    logic        fault_any;
    logic        fo_expire;
    localparam int IRQ_W_L = reset_seq_pkg::IRQ_W;

    logic        cnt_done;
    logic [IRQ_W_L-1:0] ev;

    ////////////////////////////////////////////////////////////////////////////
    // decoded events
    always_comb begin
        req          = i_avs_read | i_avs_write;
        wr_hit       = i_avs_write & s_q.ack;
        warm_req     = wr_hit
                     & (i_avs_address == reset_seq_pkg::OFF_CTRL)
                     & i_avs_writedata[reset_seq_pkg::CTRL_WARM_RST_BIT];
        soft_req     = |i_soft_reset_req;
        power_toggle = |i_power_req;
        fault_any    = |i_monitor_fault;
        // timer expires only while armed; the halt pin wins in its own cycle
        fo_expire    = (s_q.state == reset_seq_pkg::ST_INIT
                     || s_q.state == reset_seq_pkg::ST_BRIDGE_RST
                     || s_q.state == reset_seq_pkg::ST_RUN)
                     & ~s_q.fo_halted & i_failover_timer_halt_n
                     & (s_q.fo_cnt >= 32'(FAILOVER_TIMEOUT - 1));
        cnt_done     = 1'b0;
        case (s_q.state)
            reset_seq_pkg::ST_STABLE:
                cnt_done = s_q.seq_cnt >= 32'(PGOOD_STABLE - 1);
            reset_seq_pkg::ST_BRIDGE_RST:
                cnt_done = s_q.seq_cnt >= 32'(BRIDGE_RESET - 1);
            reset_seq_pkg::ST_FAILOVER:
                cnt_done = s_q.seq_cnt >= 32'(FAILOVER_RESET - 1);
            reset_seq_pkg::ST_CPU_RST:
                cnt_done = s_q.seq_cnt >= 32'(CPU_RESET - 1);
            default:
                cnt_done = 1'b0;
        endcase
        ev = '0;
        ev[reset_seq_pkg::EV_FAILOVER]   = fo_expire;
        ev[reset_seq_pkg::EV_SOFT_RST]   = soft_req
                                         & (s_q.state == reset_seq_pkg::ST_RUN);
        ev[reset_seq_pkg::EV_MGMT_FAULT] = fault_any & ~s_q.fault_prev;
        ev[reset_seq_pkg::EV_POWER_REQ]  = power_toggle;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.seq_cnt    = s_q.seq_cnt + 32'h1;
        s_d.fault_prev = fault_any;
        s_d.io_reset_n = o_board.host_bridge_reset_n; // io follows

        // power switching from any request source
        if (power_toggle) begin
            s_d.power_on = ~s_q.power_on;
        end

        // failover timer, armed from power good until halted
        if (s_q.state == reset_seq_pkg::ST_INIT
            || s_q.state == reset_seq_pkg::ST_BRIDGE_RST
            || s_q.state == reset_seq_pkg::ST_RUN) begin
            s_d.fo_cnt = s_q.fo_cnt + 32'h1;
            if (!i_failover_timer_halt_n) begin
                s_d.fo_halted = 1'b1;
            end
        end

        case (s_q.state)
            reset_seq_pkg::ST_OFF: begin
                s_d.seq_cnt = '0;
                if (s_q.power_on && i_power_stable) begin
                    s_d.state = reset_seq_pkg::ST_STABLE;
                end
            end
            reset_seq_pkg::ST_STABLE: begin
                // any dip of the supply restarts the wait
                if (!i_power_stable) begin
                    s_d.seq_cnt = '0;
                end else if (cnt_done) begin
                    s_d.state     = reset_seq_pkg::ST_INIT;
                    s_d.seq_cnt   = '0;
                    s_d.fo_cnt    = '0;
                    s_d.fo_halted = 1'b0;
                    s_d.excl_cpu0 = 1'b0;
                    s_d.cause     = reset_seq_pkg::CAUSE_POWER_UP;
                    s_d.bridge_pending = 1'b1;
                end
            end
            reset_seq_pkg::ST_INIT: begin
                // processors run self test here; wait for their done
                s_d.seq_cnt = '0;
                if (fo_expire) begin
                    s_d.state = reset_seq_pkg::ST_FAILOVER;
                end else if (i_cpu_init_done) begin
                    s_d.state = s_q.bridge_pending
                              ? reset_seq_pkg::ST_BRIDGE_RST
                              : reset_seq_pkg::ST_RUN;
                end
            end
            reset_seq_pkg::ST_BRIDGE_RST: begin
                if (fo_expire) begin
                    s_d.state   = reset_seq_pkg::ST_FAILOVER;
                    s_d.seq_cnt = '0;
                end else if (cnt_done) begin
                    s_d.state          = reset_seq_pkg::ST_RUN;
                    s_d.bridge_pending = 1'b0;
                end
            end
            reset_seq_pkg::ST_RUN: begin
                s_d.seq_cnt = '0;
                if (fo_expire) begin
                    s_d.state = reset_seq_pkg::ST_FAILOVER;
                end else if (warm_req) begin
                    s_d.state          = reset_seq_pkg::ST_CPU_RST;
                    s_d.cause          = reset_seq_pkg::CAUSE_WARM;
                    s_d.bridge_pending = 1'b1;
                end else if (soft_req) begin
                    s_d.state = reset_seq_pkg::ST_CPU_RST;
                    s_d.cause = reset_seq_pkg::CAUSE_SOFT;
                end
            end
            reset_seq_pkg::ST_FAILOVER: begin
                if (cnt_done) begin
                    // timer stays disarmed so processor 1 is not cut short
                    s_d.state     = reset_seq_pkg::ST_INIT;
                    s_d.excl_cpu0 = 1'b1;
                    s_d.fo_halted = 1'b1;
                end
            end
            reset_seq_pkg::ST_CPU_RST: begin
                if (cnt_done) begin
                    s_d.state = reset_seq_pkg::ST_INIT;
                end
            end
            default: begin
                s_d.state = reset_seq_pkg::ST_OFF;
            end
        endcase

        // power removal overrides the whole sequence
        if (!s_q.power_on || !i_power_stable) begin
            if (s_q.state != reset_seq_pkg::ST_OFF
                && s_q.state != reset_seq_pkg::ST_STABLE) begin
                s_d.state = reset_seq_pkg::ST_OFF;
            end
        end
        if (!s_q.power_on) begin
            s_d.state = reset_seq_pkg::ST_OFF;
        end

        // register slave: one wait cycle, read data captured meanwhile
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack) begin
            case (i_avs_address)
                reset_seq_pkg::OFF_CTRL:
                    s_d.rdata = {29'h0, s_q.ctrl[2:1], 1'b0};
                reset_seq_pkg::OFF_STATUS: begin
                    s_d.rdata = 32'h0;
                    s_d.rdata[reset_seq_pkg::STAT_STATE_LSB +: 3] = s_q.state;
                    s_d.rdata[reset_seq_pkg::STAT_CAUSE_LSB +: 2] = s_q.cause;
                    s_d.rdata[reset_seq_pkg::STAT_EXCL_BIT]   = s_q.excl_cpu0;
                    s_d.rdata[reset_seq_pkg::STAT_HALTED_BIT] = s_q.fo_halted;
                    s_d.rdata[reset_seq_pkg::STAT_PGOOD_BIT]  =
                        o_board.cpu_power_good;
                    s_d.rdata[reset_seq_pkg::STAT_POWER_BIT]  = s_q.power_on;
                end
                reset_seq_pkg::OFF_IRQ_STATUS:
                    s_d.rdata = {28'h0, s_q.irq_status};
                reset_seq_pkg::OFF_IRQ_MASK:
                    s_d.rdata = {28'h0, s_q.irq_mask};
                default:
                    s_d.rdata = 32'h0;
            endcase
        end
        if (wr_hit && i_avs_address == reset_seq_pkg::OFF_CTRL) begin
            s_d.ctrl = {i_avs_writedata[2:1], 1'b0};
        end
        if (wr_hit && i_avs_address == reset_seq_pkg::OFF_IRQ_MASK) begin
            s_d.irq_mask = i_avs_writedata[IRQ_W_L-1:0];
        end
        // write one clears; a new event in the same cycle wins
        if (wr_hit && i_avs_address == reset_seq_pkg::OFF_IRQ_STATUS) begin
            s_d.irq_status = s_q.irq_status & ~i_avs_writedata[IRQ_W_L-1:0];
        end
        s_d.irq_status = s_d.irq_status | ev;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q            <= '0;
            s_q.state      <= reset_seq_pkg::ST_OFF;
            s_q.cause      <= reset_seq_pkg::CAUSE_POWER_UP;
            s_q.io_reset_n <= 1'b0;
            s_q.ctrl       <= reset_seq_pkg::CTRL_RESET;
            s_q.irq_mask   <= reset_seq_pkg::IRQ_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // board outputs, decoded from registered state only
    logic in_pgood;
    always_comb begin
        in_pgood = s_q.state != reset_seq_pkg::ST_OFF
                && s_q.state != reset_seq_pkg::ST_STABLE;
        o_board.main_power_on       = s_q.power_on;
        o_board.cpu_power_good      = in_pgood;
        o_board.board_ctrl_reset_n  = in_pgood;
        o_board.cpu_clock_en        = in_pgood;
        o_board.cpu_reset_n         = in_pgood
            && s_q.state != reset_seq_pkg::ST_FAILOVER
            && s_q.state != reset_seq_pkg::ST_CPU_RST;
        o_board.bus_reset_n         = o_board.cpu_reset_n;
        // soft reset leaves cache contents alone
        o_board.cache_invalidate    = !o_board.cpu_reset_n
            && s_q.cause != reset_seq_pkg::CAUSE_SOFT;
        o_board.stop_flush          =
            s_q.state == reset_seq_pkg::ST_FAILOVER;
        o_board.failover_reset_n    =
            s_q.state != reset_seq_pkg::ST_FAILOVER;
        o_board.cpu0_boot_exclude   = s_q.excl_cpu0;
        o_board.host_bridge_reset_n = s_q.state != reset_seq_pkg::ST_BRIDGE_RST
            && in_pgood && !(s_q.bridge_pending
            && s_q.cause == reset_seq_pkg::CAUSE_POWER_UP);
        o_board.io_reset_n          = s_q.io_reset_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts, bus answer and error routing
    always_comb begin
        o_avs_readdata     = s_q.rdata;
        o_avs_waitrequest  = req & ~s_q.ack;
        o_irq              = |(s_q.irq_status & s_q.irq_mask);
        o_mgmt_interrupt_n = ~fault_any;
        o_pci_serr_n       = ~((fault_any
                             & s_q.ctrl[reset_seq_pkg::CTRL_SMI_GATE_BIT])
                           | (i_nmi
                             & s_q.ctrl[reset_seq_pkg::CTRL_NMI_GATE_BIT]));
    end

endmodule

`default_nettype wire

// ---- logic/reset_seq_pkg.sv ----
// shared constants, types and register layout of the reset and boot failover block
package reset_seq_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0] OFF_CTRL       = 4'h0;
    localparam logic [3:0] OFF_STATUS     = 4'h4;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK   = 4'hC;

    // control register fields
    localparam int CTRL_WARM_RST_BIT = 0;  // write one: programmed warm reset
    localparam int CTRL_SMI_GATE_BIT = 1;  // route mgmt interrupt to serr
    localparam int CTRL_NMI_GATE_BIT = 2;  // route nmi to serr
    localparam logic [2:0] CTRL_RESET = 3'h6;

    // status register fields
    localparam int STAT_STATE_LSB   = 0;   // 3 bits of sequence state
    localparam int STAT_CAUSE_LSB   = 4;   // 2 bits of last reset cause
    localparam int STAT_EXCL_BIT    = 8;   // processor 0 excluded from boot
    localparam int STAT_HALTED_BIT  = 9;   // failover timer halted
    localparam int STAT_PGOOD_BIT   = 10;  // cpu power good
    localparam int STAT_POWER_BIT   = 11;  // main power switched on

    // interrupt event bits
    localparam int IRQ_W            = 4;
    localparam int EV_FAILOVER      = 0;
    localparam int EV_SOFT_RST      = 1;
    localparam int EV_MGMT_FAULT    = 2;
    localparam int EV_POWER_REQ     = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // timing
    localparam int CLK_MHZ              = 250;
    localparam int FAILOVER_RESET_MS    = 10;
    localparam int FAILOVER_RESET_CYC   = FAILOVER_RESET_MS * CLK_MHZ * 1000;
    localparam int FAILOVER_TIMEOUT_CYC = 250000000;
    localparam int PGOOD_STABLE_CYC     = 1024;
    localparam int BRIDGE_RESET_CYC     = 256;
    localparam int CPU_RESET_CYC        = 64;

    typedef enum logic [1:0] {
        CAUSE_POWER_UP,
        CAUSE_WARM,
        CAUSE_SOFT
    } cause_type;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_STABLE,
        ST_INIT,
        ST_BRIDGE_RST,
        ST_RUN,
        ST_FAILOVER,
        ST_CPU_RST
    } seq_state_type;

    // board side outputs, carried together
    typedef struct packed {
        logic main_power_on;
        logic cpu_power_good;
        logic board_ctrl_reset_n;
        logic cpu_clock_en;
        logic cpu_reset_n;
        logic bus_reset_n;
        logic cache_invalidate;
        logic stop_flush;
        logic failover_reset_n;
        logic cpu0_boot_exclude;
        logic host_bridge_reset_n;
        logic io_reset_n;
    } board_out_type;

    typedef struct packed {
        seq_state_type   state;
        cause_type       cause;
        logic [31:0]     seq_cnt;
        logic [31:0]     fo_cnt;
        logic            fo_halted;
        logic            excl_cpu0;
        logic            power_on;
        logic            bridge_pending;
        logic            io_reset_n;
        logic [2:0]      ctrl;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic            fault_prev;
        logic            ack;
        logic [31:0]     rdata;
    } state_type;

endpackage

// ---- tb/server_reset_asserts.sv ----
// concurrent checks on the ports of the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module server_reset_asserts #(
    parameter int FAILOVER_RESET = 50
) (
    input wire logic                    i_clk,
    input wire logic                    i_srst,
    input wire logic                    i_avs_read,
    input wire logic                    i_avs_write,
    input wire logic                    o_avs_waitrequest,
    input wire logic [3:0]              i_power_req,
    input wire logic                    i_power_stable,
    input wire logic                    i_cpu_init_done,
    input wire logic [3:0]              i_monitor_fault,
    input wire logic                    i_nmi,
    input wire reset_seq_pkg::board_out_type o_board,
    input wire logic                    o_mgmt_interrupt_n,
    input wire logic                    o_pci_serr_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////
    // length of the failover reset pulse, counted while it is low
    int lo_cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_srst || o_board.failover_reset_n)
            lo_cnt_q <= 0;
        else
            lo_cnt_q <= lo_cnt_q + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    mgmt_irq_level_a: assert property (
        o_mgmt_interrupt_n == !(|i_monitor_fault))
        else $error("mgmt interrupt does not follow faults");
    serr_quiet_a: assert property (
        (!(|i_monitor_fault) && !i_nmi) |-> o_pci_serr_n)
        else $error("serr low with no source");
    pgood_after_stable_a: assert property (
        $rose(o_board.cpu_power_good) |->
            o_board.main_power_on && $past(i_power_stable))
        else $error("power good rose without stable power");
    pgood_release_a: assert property (
        $rose(o_board.cpu_power_good) |->
            o_board.cpu_clock_en && o_board.board_ctrl_reset_n)
        else $error("clocks or board controller late at power good");
    pgood_hold_a: assert property (
        !o_board.cpu_power_good |-> !o_board.board_ctrl_reset_n)
        else $error("board controller out of reset without power good");
    failover_flush_a: assert property (
        $fell(o_board.failover_reset_n) |-> o_board.stop_flush)
        else $error("failover reset without stop flush");
    failover_length_a: assert property (
        $rose(o_board.failover_reset_n) |-> lo_cnt_q == FAILOVER_RESET)
        else $error("failover reset pulse has wrong length");
    cpu0_excluded_a: assert property (
        $rose(o_board.failover_reset_n) |-> ##[0:1] o_board.cpu0_boot_exclude)
        else $error("processor 0 not excluded after failover");
    io_follows_bridge_a: assert property (
        o_board.io_reset_n == $past(o_board.host_bridge_reset_n))
        else $error("io reset does not follow bridge reset");
    bridge_after_init_a: assert property (
        $rose(o_board.host_bridge_reset_n) |-> $past(i_cpu_init_done))
        else $error("bridge released before processor init");
    bus_with_cpu_a: assert property (
        $fell(o_board.bus_reset_n) |-> !o_board.cpu_reset_n)
        else $error("bus reset without processor reset");
    power_toggle_a: assert property (
        |i_power_req |=> o_board.main_power_on != $past(o_board.main_power_on))
        else $error("power request ignored");
    one_wait_a: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("more than one wait state");
    cover_failover_c: cover property ($rose(o_board.failover_reset_n));
    cover_soft_c: cover property ($fell(o_board.cpu_reset_n) &&
        !o_board.cache_invalidate);
    cover_power_c: cover property ($fell(o_board.main_power_on));
endmodule
bind server_reset_and_boot_failover server_reset_asserts #(
    .FAILOVER_RESET(FAILOVER_RESET)
) server_reset_asserts_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_power_req(i_power_req), .i_power_stable(i_power_stable),
    .i_cpu_init_done(i_cpu_init_done), .i_monitor_fault(i_monitor_fault),
    .i_nmi(i_nmi), .o_board(o_board),
    .o_mgmt_interrupt_n(o_mgmt_interrupt_n), .o_pci_serr_n(o_pci_serr_n)
);
`default_nettype wire

// ---- tb/cpu_partner_model.sv ----
// behavioural model of the processors facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_partner_model (
    input  wire logic i_clk,
    input  wire logic i_cpu_reset_n,
    input  wire logic i_healthy,
    output logic      o_init_done,
    output logic      o_timer_halt_n
);
    int bist_q = 0;
    // self test runs from reset release; restarts on every processor reset
    always @(posedge i_clk) begin
        if (i_cpu_reset_n !== 1'b1)
            bist_q <= 0;
        else
            bist_q <= bist_q + 1;
    end
    // init done only once self test ends; gated at once by a new reset
    assign o_init_done = (i_cpu_reset_n === 1'b1) && (bist_q >= 6);
    // only a healthy processor halts the timer, a while after booting
    assign o_timer_halt_n = !((i_cpu_reset_n === 1'b1) && i_healthy
                              && (bist_q >= 9));
endmodule
`default_nettype wire

// ---- tb/server_reset_and_boot_failover_test.sv ----
// self-checking bench of the reset sequencer and boot failover
`timescale 1ns/10ps
`default_nettype none
module server_reset_and_boot_failover_test;
    localparam int FR = 50;
    localparam logic [3:0] A_CT = reset_seq_pkg::OFF_CTRL;
    localparam logic [3:0] A_ST = reset_seq_pkg::OFF_STATUS;
    localparam logic [3:0] A_IS = reset_seq_pkg::OFF_IRQ_STATUS;
    localparam logic [3:0] A_IM = reset_seq_pkg::OFF_IRQ_MASK;
    logic        clk, srst, rd, wr, stab, nmi, healthy, wreq, irq, seen;
    logic        mgmt_n, serr_n, init_done, halt_n;
    logic [1:0]  g;
    logic [2:0]  sreq;
    logic [3:0]  adr, preq, fault;
    logic [31:0] wd, rdat, q;
    reset_seq_pkg::board_out_type brd;
    int          err_count, total_checks, exp_irq, k, n;
    server_reset_and_boot_failover #(.FAILOVER_TIMEOUT(200),
        .FAILOVER_RESET(FR), .PGOOD_STABLE(8), .BRIDGE_RESET(8),
        .CPU_RESET(8)) server_reset_and_boot_failover_i (
        .i_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_irq(irq), .i_power_req(preq),
        .i_power_stable(stab), .i_cpu_init_done(init_done),
        .i_failover_timer_halt_n(halt_n), .i_soft_reset_req(sreq),
        .i_monitor_fault(fault), .i_nmi(nmi), .o_board(brd),
        .o_mgmt_interrupt_n(mgmt_n), .o_pci_serr_n(serr_n));
    cpu_partner_model cpu_partner_model_i (.i_clk(clk),
        .i_cpu_reset_n(brd.cpu_reset_n), .i_healthy(healthy),
        .o_init_done(init_done), .o_timer_halt_n(halt_n));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] gt);
        total_checks++;
        if (gt !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, gt);
        end
    endtask
    // one bus access; request held until waitrequest is sampled low
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a; wd <= d; wr <= w; rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0; rd <= 1'b0;
    endtask
    // poll the sequence state under a bounded count
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 300; i++) begin
            av(1'b0, A_ST, 32'h0);
            if (q[2:0] === s) break;
        end
        chk("state", 32'(s), 32'(q[2:0]));
    endtask
    task automatic pulse_pwr(input int b);
        @(posedge clk); preq[b] <= 1'b1;
        @(posedge clk); preq <= 4'h0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: the whole run needs far fewer cycles than this
    initial begin
        #(4 * 40000);
        err_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 4'h0; wd = 32'h0; nmi = 1'b0;
        stab = 1'b0; healthy = 1'b1; preq = 4'h0; fault = 4'h0; sreq = 3'h0;
        err_count = 0; total_checks = 0; exp_irq = 0;
        k = $urandom(66155);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        av(1'b0, A_CT, 32'h0); chk("ctrl reset", 32'h6, q);
        av(1'b0, A_IM, 32'h0); chk("mask reset", 32'h0, q);
        av(1'b0, 4'h1, 32'h0); chk("unmapped", 32'h0, q);
        av(1'b1, A_ST, 32'hFFF);
        wait_st(3'd0);
        chk("pgood off", 32'h0, 32'(brd.cpu_power_good));
        $display("test reset values done");
        // power-up with a healthy processor
        av(1'b1, A_IM, 32'hF);
        stab <= 1'b1;
        pulse_pwr(int'($urandom % 4));
        exp_irq = 8;
        wait_st(3'd4);
        chk("pgood", 32'h1, 32'(q[10]));
        chk("halted", 32'h1, 32'(q[9]));
        chk("clock en", 32'h1, 32'(brd.cpu_clock_en));
        chk("io out", 32'h1, 32'(brd.io_reset_n));
        chk("irq line", 32'h1, 32'(irq));
        av(1'b0, A_IS, 32'h0); chk("irq status", 32'(exp_irq), q);
        repeat (240) @(posedge clk);
        wait_st(3'd4);
        $display("test power-up done");
        // soft reset from each source
        for (int s = 0; s < 3; s++) begin
            @(posedge clk); sreq[s] <= 1'b1;
            @(posedge clk); sreq <= 3'h0;
            @(posedge clk);
            chk("cpu rst", 32'h0, 32'(brd.cpu_reset_n));
            chk("bus rst", 32'h0, 32'(brd.bus_reset_n));
            chk("cache kept", 32'h0, 32'(brd.cache_invalidate));
            exp_irq = exp_irq | 2;
            wait_st(3'd4);
            chk("cause", 32'h2, 32'(q[5:4]));
        end
        av(1'b0, A_IS, 32'h0); chk("irq soft", 32'(exp_irq), q);
        av(1'b1, A_IS, 32'hF);
        exp_irq = 0;
        av(1'b0, A_IS, 32'h0); chk("irq clear", 32'(exp_irq), q);
        chk("irq low", 32'h0, 32'(irq));
        $display("test soft reset done");
        // programmed warm reset through the control register
        av(1'b1, A_CT, 32'h7);
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk);
            if (brd.cache_invalidate === 1'b1) seen = 1'b1;
        end
        chk("warm flush", 32'h1, 32'(seen));
        wait_st(3'd4);
        chk("cause", 32'h1, 32'(q[5:4]));
        av(1'b0, A_CT, 32'h0); chk("ctrl self clear", 32'h6, q);
        $display("test warm reset done");
        // management interrupt and serr routing
        for (int i = 0; i < 10; i++) begin
            g = 2'($urandom);
            av(1'b1, A_CT, 32'(g) << 1);
            fault <= 4'($urandom); nmi <= 1'($urandom);
            @(posedge clk); @(posedge clk);
            chk("mgmt", 32'(!(|fault)), 32'(mgmt_n));
            chk("serr", 32'(!((|fault && g[0]) || (nmi && g[1]))),
                32'(serr_n));
        end
        fault <= 4'h0; nmi <= 1'b0;
        $display("test interrupt routing done");
        // failover with a processor that never halts the timer
        srst <= 1'b1; healthy <= 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        pulse_pwr(2);
        for (n = 0; n < 3000 && brd.failover_reset_n !== 1'b0; n++)
            @(posedge clk);
        chk("stop flush", 32'h1, 32'(brd.stop_flush));
        for (n = 0; n < 3000 && brd.failover_reset_n === 1'b0; n++)
            @(posedge clk);
        chk("failover len", 32'(FR), 32'(n));
        wait_st(3'd4);
        chk("cpu0 excluded", 32'h1, 32'(q[8]));
        av(1'b0, A_IS, 32'h0); chk("irq failover", 32'h1, q & 32'h1);
        pulse_pwr(1);
        wait_st(3'd0);
        chk("power off", 32'h0, 32'(q[11]));
        $display("test failover done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
